// ### hw/afepm_defines.svh
// constants for the front-end mode-control decoder
`ifndef AFEPM_DEFINES_SVH
`define AFEPM_DEFINES_SVH

`define AFEPM_CMD_BITS 16
`define AFEPM_SEL_MODE 4'h0
// word field positions
`define AFEPM_SEL_LSB 0
`define AFEPM_SEL_MSB 3
`define AFEPM_PM_LSB 4
`define AFEPM_PM_MSB 7
`define AFEPM_AUX_LSB 8
`define AFEPM_AUX_MSB 10
// power-mode codes (bit 3 is the switch source)
`define AFEPM_PM_OFF 3'h0
`define AFEPM_PM_IDLE 3'h1
`define AFEPM_PM_REFONLY 3'h2
`define AFEPM_PM_FS 3'h3
`define AFEPM_PM_SF 3'h4
`define AFEPM_PM_SS 3'h5
`define AFEPM_PM_FF 3'h6
`define AFEPM_PM_CSR 4'hB
`define AFEPM_PM_CST 4'hC
`define AFEPM_PM_CFR 4'hD
`define AFEPM_PM_CFT 4'hE
// reset values
`define AFEPM_RST_PM 4'h4
`define AFEPM_RST_AUX 3'h0

`endif

// ### hw/afepm_pkg.sv
// types for the front-end mode-control decoder
package afepm_pkg;
  typedef enum logic [1:0] {
    AFEPM_ST_OFF,
    AFEPM_ST_IDLE,
    AFEPM_ST_REFONLY,
    AFEPM_ST_ACTIVE
  } afepm_pwr_e;

  typedef struct packed {
    logic adc_on;
    logic dac_on;
    logic clk_on;
    logic ref_on;
    logic aux_off_all;
    logic bus_rx;
    logic bus_tx;
  } afepm_ctl_s;

  typedef struct packed {
    logic [3:0] power_mode;
    logic [2:0] aux_disable;
  } afepm_cfg_s;
endpackage : afepm_pkg

// ### hw/afepm_serial_rx.sv
// serial command shifter on the link clock, toggle handoff of each word
`timescale 1ns/1ns
`default_nettype none
`include "afepm_defines.svh"
module afepm_serial_rx (
  input wire logic sclk, // link serial clock
  input wire logic cs_n, // chip select, active low
  input wire logic rstn, // clears the word toggle, active low
  input wire logic din, // serial data in
  output logic [15:0] word_r, // last complete word
  output logic word_tgl_r // toggles once per latched word
);
  logic [15:0] shift_r;
  logic [4:0] cnt_r;
  logic [15:0] shift_nxt;
  logic [4:0] cnt_nxt;

  // cs_n resets the frame so no edge after a frame is needed
  always_comb begin
    shift_nxt = {shift_r[14:0], din}; // see R16
    cnt_nxt = (cnt_r == 5'h10) ? cnt_r : cnt_r + 5'h01;
  end

  always_ff @(posedge sclk or posedge cs_n) begin
    if (cs_n) begin
      cnt_r <= 5'h00;
    end else begin
      cnt_r <= cnt_nxt;
    end
  end

  always_ff @(posedge sclk) begin
    if (!cs_n) begin
      shift_r <= shift_nxt;
    end
  end

  // word is applied at cs_n rising; short frames are dropped; reset puts
  // the toggle at a known level so the far side sees no false word
  always_ff @(posedge cs_n or negedge rstn) begin
    if (!rstn) begin
      word_r <= 16'h0000;
      word_tgl_r <= 1'b0;
    end else if (cnt_r == 5'h10) begin
      word_r <= shift_r; // see R16
      word_tgl_r <= ~word_tgl_r;
    end
  end
endmodule : afepm_serial_rx
`default_nettype wire

// ### hw/afepm_sync.sv
// two-flop level synchroniser, with enable
`timescale 1ns/1ns
`default_nettype none
module afepm_sync #(
  parameter int W = 1
) (
  input wire logic clk, // destination clock
  input wire logic rstn, // sync reset, active low
  input wire logic ce, // clock enable
  input wire logic [W-1:0] d, // async input
  output logic [W-1:0] q // synchronised output
);
  logic [W-1:0] m_r;
  logic [W-1:0] q_r;

  always_ff @(posedge clk) begin
    if (!rstn) begin
      m_r <= '0;
      q_r <= '0;
    end else if (ce) begin
      m_r <= d;
      q_r <= m_r;
    end
  end

  assign q = q_r;
endmodule : afepm_sync
`default_nettype wire

// ### hw/afepm_top.sv
// mode-control decoder: serial command, power state and tx/rx switching
// What this block does
// R1: codes x000 shut everything down and ignore the tx/rx pin.
// R2: codes x001 idle: converters off, aux held, clock and reference on.
// R3: codes x010 standby: converters and clock off, reference on, aux held.
// R4: pin low selects receive, high selects transmit in pin schemes.
// R5: code 0011: receive both on; transmit ADC off, DAC on.
// R6: code 0100: receive ADC only; transmit both converters on.
// R7: code 0101: receive ADC only; transmit DAC only.
// R8: code 0110: both converters on always; only bus direction follows pin.
// R9: code 1011: command slow receive, ADC on, DAC off, bus out.
// R10: code 1100: command slow transmit, ADC off, DAC on, bus in.
// R11: code 1101: command fast receive, both on, bus out.
// R12: code 1110: command fast transmit, both on, bus in.
// R13: three aux disable bits, top for aux 3, one means off.
// R14: ADC and DAC run from one shared converter clock.
// R15: ADC samples on the rising converter clock edge.
// R16: 16-bit MSB-first words on rising sclk, applied at cs_n high.
// R17: top power-mode bit picks pin control (0) or command control (1).
// R18: reset starts in pin slow-fast scheme, receive state.
// R19: bus tri-stated when inactive; last converted word shown on return.
// R20: undefined power-mode codes leave the previous state unchanged.
// R21: only mode-control words change power mode and aux enables.
`timescale 1ns/1ns
`default_nettype none
`include "afepm_defines.svh"
module afepm_top #(
  parameter int DW = 10
) (
  input wire logic clk, // shared converter clock, 10 MHz
  input wire logic rstn, // reset, active low; synchronous on clk, asynchronous in the serial receiver
  input wire logic ce, // clock enable
  input wire logic sclk, // serial link clock
  input wire logic cs_n, // serial chip select, active low
  input wire logic din, // serial data in
  input wire logic tx_sel, // tx/rx select pin, high is transmit
  input wire logic [DW-1:0] adc_sample, // converter result
  input wire logic [DW-1:0] bus_in, // parallel bus input
  output logic [DW-1:0] bus_out, // parallel bus output
  output logic bus_oe, // bus drive enable
  output logic [DW-1:0] dac_word, // word to DAC
  output logic adc_en, // receive converter powered
  output logic dac_en, // transmit converter powered
  output logic clk_dist_en, // clock distribution on
  output logic ref_en, // reference on
  output logic [2:0] aux_en, // aux DAC enables, bit 2 is aux 3
  output logic tx_state, // current state is transmit
  output afepm_pkg::afepm_pwr_e pwr_state, // power state
  output afepm_pkg::afepm_cfg_s cfg // applied mode-control settings
);
  import afepm_pkg::*;

  logic [15:0] link_word;
  logic link_tgl;
  logic tgl_q;
  logic tgl_seen_r;
  logic tgl_seen_nxt;
  logic [15:0] cmd_r;
  logic [15:0] cmd_nxt;
  logic cmd_vld_r;
  logic cmd_vld_nxt;
  afepm_cfg_s cfg_r;
  afepm_cfg_s cfg_nxt;
  afepm_ctl_s ctl;
  afepm_pwr_e pwr;
  logic tx_now;
  logic [DW-1:0] bus_out_r;
  logic [DW-1:0] bus_out_nxt;
  logic [DW-1:0] dac_r;
  logic [DW-1:0] dac_nxt;
  logic [DW-1:0] last_adc_r;
  logic [DW-1:0] last_adc_nxt;
  logic bus_oe_r;
  logic bus_oe_nxt;
  logic [3:0] pm;
  logic [DW-1:0] bus_in_q;
  wire logic [2:0] aux_on;

  afepm_serial_rx u_rx (
    .sclk(sclk),
    .cs_n(cs_n),
    .rstn(rstn),
    .din(din),
    .word_r(link_word),
    .word_tgl_r(link_tgl)
  );

  // only the toggle is synchronised; the word is held from one cs_n rise
  // to the next, so it is steady long before the toggle has crossed and
  // cannot be caught with bits in mid-change
  afepm_sync #(.W(1)) u_sync_link (
    .clk(clk),
    .rstn(rstn),
    .ce(ce),
    .d(link_tgl),
    .q(tgl_q)
  );

  afepm_sync #(.W(1)) u_sync_pin (
    .clk(clk),
    .rstn(rstn),
    .ce(ce),
    .d(tx_sel),
    .q(tx_now)
  );

  // a toggle change marks a fresh word; copy it once into this domain.
  // two words closer than the crossing time would cancel each other's
  // toggle, so the controller must keep them apart
  always_comb begin
    tgl_seen_nxt = tgl_q;
    cmd_vld_nxt = tgl_q != tgl_seen_r;
    cmd_nxt = cmd_r;
    if (cmd_vld_nxt) begin
      cmd_nxt = link_word; // see R16
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      tgl_seen_r <= 1'b0;
      cmd_vld_r <= 1'b0;
      cmd_r <= 16'h0000;
    end else if (ce) begin
      tgl_seen_r <= tgl_seen_nxt;
      cmd_vld_r <= cmd_vld_nxt;
      cmd_r <= cmd_nxt;
    end
  end

  // power-mode field of a command word
  function automatic logic [3:0] pm_field(input logic [15:0] w);
    return w[`AFEPM_PM_MSB:`AFEPM_PM_LSB];
  endfunction : pm_field

  // true for power-mode codes listed in any table
  function automatic logic pm_known(input logic [3:0] c);
    logic ok;
    ok = 1'b0;
    if (c[2:0] <= `AFEPM_PM_FF) begin
      ok = !c[3] || c[2:0] <= `AFEPM_PM_REFONLY;
    end
    if (c == `AFEPM_PM_CSR || c == `AFEPM_PM_CST) begin
      ok = 1'b1;
    end
    if (c == `AFEPM_PM_CFR || c == `AFEPM_PM_CFT) begin
      ok = 1'b1;
    end
    return ok;
  endfunction : pm_known

  // aux bits follow every mode word; an undefined power code is dropped
  always_comb begin
    cfg_nxt = cfg_r;
    if (cmd_vld_r &&
        cmd_r[`AFEPM_SEL_MSB:`AFEPM_SEL_LSB] == `AFEPM_SEL_MODE) begin
      cfg_nxt.aux_disable =
        cmd_r[`AFEPM_AUX_MSB:`AFEPM_AUX_LSB]; // see R21 see R13
      if (pm_known(pm_field(cmd_r))) begin
        cfg_nxt.power_mode = pm_field(cmd_r); // see R20
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      cfg_r.power_mode <= `AFEPM_RST_PM; // see R18
      cfg_r.aux_disable <= `AFEPM_RST_AUX;
    end else if (ce) begin
      cfg_r <= cfg_nxt;
    end
  end

  assign pm = cfg_r.power_mode;

  // power decode; low states ignore pin whatever the top bit
  always_comb begin
    ctl = '0;
    pwr = AFEPM_ST_ACTIVE;
    unique case (pm[2:0])
      `AFEPM_PM_OFF: begin
        pwr = AFEPM_ST_OFF;
        ctl.aux_off_all = 1'b1; // see R1
      end
      `AFEPM_PM_IDLE: begin
        pwr = AFEPM_ST_IDLE;
        ctl.clk_on = 1'b1; // see R2
        ctl.ref_on = 1'b1;
      end
      `AFEPM_PM_REFONLY: begin
        pwr = AFEPM_ST_REFONLY;
        ctl.ref_on = 1'b1; // see R3
      end
      default: begin
        ctl.clk_on = 1'b1;
        ctl.ref_on = 1'b1;
        if (!pm[3]) begin // see R17 see R4
          ctl.bus_tx = tx_now;
          unique case (pm[2:0])
            `AFEPM_PM_FS: begin
              ctl.adc_on = !tx_now; // see R5
              ctl.dac_on = 1'b1;
            end
            `AFEPM_PM_SF: begin
              ctl.adc_on = 1'b1; // see R6
              ctl.dac_on = tx_now;
            end
            `AFEPM_PM_SS: begin
              ctl.adc_on = !tx_now; // see R7
              ctl.dac_on = tx_now;
            end
            default: begin
              ctl.adc_on = 1'b1; // see R8
              ctl.dac_on = 1'b1;
            end
          endcase
        end else begin
          ctl.bus_tx = pm[2] && !pm[0] || pm == `AFEPM_PM_CST;
          unique case (pm)
            `AFEPM_PM_CSR: ctl.adc_on = 1'b1; // see R9
            `AFEPM_PM_CST: ctl.dac_on = 1'b1; // see R10
            default: begin
              ctl.adc_on = 1'b1; // see R11 see R12
              ctl.dac_on = 1'b1;
            end
          endcase
        end
        ctl.bus_rx = !ctl.bus_tx;
      end
    endcase
  end

  // the parallel bus shares the converter clock, so no synchroniser
  assign bus_in_q = bus_in;

  // bus and data registers all run on the shared converter clock
  always_comb begin
    last_adc_nxt = last_adc_r;
    if (ctl.adc_on) begin
      last_adc_nxt = adc_sample; // see R14 see R15
    end
    bus_oe_nxt = ctl.bus_rx; // see R19
    // hold word while off so the last conversion shows first on return
    bus_out_nxt = ctl.bus_rx ? last_adc_r : bus_out_r; // see R19
    dac_nxt = (ctl.bus_tx && ctl.dac_on) ? bus_in_q : dac_r;
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      last_adc_r <= '0;
      bus_out_r <= '0;
      bus_oe_r <= 1'b0;
      dac_r <= '0;
    end else if (ce) begin
      last_adc_r <= last_adc_nxt;
      bus_out_r <= bus_out_nxt;
      bus_oe_r <= bus_oe_nxt;
      dac_r <= dac_nxt;
    end
  end

  assign bus_out = bus_out_r;
  assign bus_oe = bus_oe_r;
  assign dac_word = dac_r;
  assign adc_en = ctl.adc_on;
  assign dac_en = ctl.dac_on;
  assign clk_dist_en = ctl.clk_on;
  assign ref_en = ctl.ref_on;
  // aux off in shutdown; idle and standby keep the held settings
  for (genvar i = 0; i < 3; i++) begin : g_aux
    assign aux_on[i] = !ctl.aux_off_all && !cfg_r.aux_disable[i]; // see R13
  end
  assign aux_en = aux_on;
  assign tx_state = ctl.bus_tx;
  assign pwr_state = pwr;
  assign cfg = cfg_r;
endmodule : afepm_top
`default_nettype wire

// ### sim/afepm_sva.sv
// port assertions for the mode decoder
`timescale 1ns/1ns
`default_nettype none
module afepm_sva (
  input wire logic clk, // clock
  input wire logic rstn, // reset
  input wire logic ce, // clock enable
  input wire logic cs_n, // select
  input wire logic tx_sel, // pin
  input wire logic bus_oe, // drive
  input wire logic adc_en, // adc
  input wire logic dac_en, // dac
  input wire logic clk_dist_en, // clocks
  input wire logic ref_en, // ref
  input wire logic [2:0] aux_en, // aux
  input wire logic tx_state, // dir
  input wire afepm_pkg::afepm_pwr_e pwr_state, // state
  input wire afepm_pkg::afepm_cfg_s cfg // config
);
  import afepm_pkg::*;
  logic [3:0] pm;
  assign pm = cfg.power_mode;
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  // pin needs a few calm cycles to cross its synchroniser
  sequence pin_calm;
    !pm[3] && pm[2:0] inside {[3:6]} && $stable(tx_sel) && $stable(pm);
  endsequence
  // a word may wait in the crossing while the enable is low
  sequence link_quiet;
    (cs_n && ce) [*6];
  endsequence
  off_pwr_a: assert property (pm[2:0] == 3'h0 |->
    !adc_en && !dac_en && !ref_en && aux_en == 3'h0) else $error("off");
  idle_pwr_a: assert property (pm[2:0] == 3'h1 |->
    !adc_en && !dac_en && clk_dist_en && ref_en) else $error("idle");
  reference_only_state_pwr_a: assert property (pm[2:0] == 3'h2 |->
    !adc_en && !dac_en && !clk_dist_en && ref_en) else $error("reference_only_state");
  pin_follow_a: assert property (pin_calm [*4] |->
    tx_state == tx_sel) else $error("pin ignored");
  cmd_dir_a: assert property (pm inside {[4'hB:4'hE]} |->
    tx_state == !pm[0]) else $error("cmd dir");
  cmd_pwr_a: assert property (pm inside {[4'hB:4'hE]} |->
    adc_en == (pm != 4'hC) && dac_en == (pm != 4'hB)) else $error("cmd pwr");
  ff_on_a: assert property (pm == 4'h6 |-> adc_en && dac_en)
    else $error("ff pwr");
  aux_map_a: assert property (pwr_state != AFEPM_ST_OFF |->
    aux_en == ~cfg.aux_disable) else $error("aux");
  bus_float_a: assert property ((pwr_state != AFEPM_ST_ACTIVE) [*2]
    |-> !bus_oe) else $error("bus driven");
  cfg_quiet_a: assert property (link_quiet |=> $stable(cfg))
    else $error("cfg moved");
  reset_mode_a: assert property ($rose(rstn) |-> pm == 4'h4
    && !tx_state) else $error("reset mode");
endmodule : afepm_sva
bind afepm_top afepm_sva u_sva (.clk(clk), .rstn(rstn), .ce(ce),
  .cs_n(cs_n),
  .tx_sel(tx_sel), .bus_oe(bus_oe), .adc_en(adc_en), .dac_en(dac_en),
  .clk_dist_en(clk_dist_en), .ref_en(ref_en), .aux_en(aux_en),
  .tx_state(tx_state), .pwr_state(pwr_state), .cfg(cfg));
`default_nettype wire

// ### sim/afepm_ctrl_model.sv
// baseband controller model: serial words and tx/rx pin
`timescale 1ns/1ns
`default_nettype none
module afepm_ctrl_model (
  output var logic sclk, // runs only inside frames
  output var logic cs_n, // select, active low
  output var logic din, // serial data
  output var logic tx_sel // tx/rx pin
);
  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    din = 1'b0;
    tx_sel = 1'b0;
  end
  // odd start offset keeps the link out of phase with clk
  task automatic send(input logic [15:0] w, input int n);
    #7 cs_n = 1'b0;
    for (int i = 15; i > 15 - n; i--) begin
      din = w[i];
      #16 sclk = 1'b1;
      #16 sclk = 1'b0;
    end
    #16 cs_n = 1'b1;
    din = ~din;
    #100;
  endtask : send
  task automatic pin(input logic v);
    tx_sel = v;
  endtask : pin
endmodule : afepm_ctrl_model
`default_nettype wire

// ### sim/afepm_top_bench.sv
// self-checking bench for the mode decoder
`timescale 1ns/1ns
`default_nettype none
module afepm_top_bench;
  import afepm_pkg::*;
  logic clk, rstn, ce, sclk, cs_n, din, tx_sel;
  logic [9:0] adc_sample, bus_in, bus_out, dac_word;
  logic bus_oe, adc_en, dac_en, clk_dist_en, ref_en, tx_state;
  logic [2:0] aux_en;
  afepm_pwr_e pwr_state;
  afepm_cfg_s cfg;
  int err_count = 0;
  int compares = 0;
  int cyc = 0;
  afepm_top #(.DW(10)) DUT (.clk(clk), .rstn(rstn), .ce(ce), .sclk(sclk),
    .cs_n(cs_n), .din(din), .tx_sel(tx_sel), .adc_sample(adc_sample),
    .bus_in(bus_in), .bus_out(bus_out), .bus_oe(bus_oe),
    .dac_word(dac_word), .adc_en(adc_en), .dac_en(dac_en),
    .clk_dist_en(clk_dist_en), .ref_en(ref_en), .aux_en(aux_en),
    .tx_state(tx_state), .pwr_state(pwr_state), .cfg(cfg));
  afepm_ctrl_model ctl (.sclk(sclk), .cs_n(cs_n), .din(din),
    .tx_sel(tx_sel));
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  task automatic summarize;
    $display("compares %0d err_count %0d", compares, err_count);
    if (err_count == 0 && compares > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : summarize
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      err_count++;
      summarize;
    end
  end
  task automatic chk(input logic ok, input string m);
    compares++;
    if (ok !== 1'b1) begin
      err_count++;
      $display("mismatch at %0t: %s", $time, m);
    end
  endtask : chk
  task automatic put(input logic [3:0] pm, input logic [2:0] ax,
                     input int n = 16, input logic [3:0] sel = 4'h0);
    ctl.send({5'h00, ax, pm, sel}, n);
    repeat (8) @(negedge clk);
  endtask : put
  task automatic t_pin;
    logic [1:0] ex [8] = '{2'h3, 2'h1, 2'h2, 2'h3, 2'h2, 2'h1, 2'h3, 2'h3};
    for (int i = 0; i < 8; i++) begin
      put(4'(3 + i / 2), 3'h0);
      ctl.pin(i[0]);
      adc_sample = 10'(i * 37 + 5);
      bus_in = 10'(i * 91 + 2);
      repeat (4) @(negedge clk);
      chk({adc_en, dac_en} === ex[i], "pin powers");
      chk(tx_state === i[0] && bus_oe === !i[0], "pin dir");
      chk(i[0] ? dac_word === bus_in : bus_out === adc_sample, "data");
    end
  endtask : t_pin
  task automatic t_cmd;
    logic [1:0] ex [4] = '{2'h2, 2'h1, 2'h3, 2'h3};
    for (int i = 0; i < 4; i++) begin
      put(4'hB + 4'(i), 3'h0);
      ctl.pin(!i[0]);
      repeat (4) @(negedge clk);
      chk(tx_state === i[0], "cmd dir");
      chk({adc_en, dac_en} === ex[i], "cmd powers");
    end
  endtask : t_cmd
  task automatic t_pwr;
    int k;
    for (int i = 0; i < 6; i++) begin
      k = i % 3;
      ctl.pin(i[0]);
      put(4'(k) | (i >= 3 ? 4'h8 : 4'h0), 3'h5);
      chk(!adc_en && !dac_en && bus_oe === 1'b0, "conv off");
      chk(clk_dist_en === (k == 1) && ref_en === (k != 0), "clk ref");
      chk(aux_en === (k == 0 ? 3'h0 : 3'h2), "aux held");
      chk(pwr_state === afepm_pwr_e'(k), "state");
    end
    ctl.pin(1'b0);
    put(4'h4, 3'h0);
    chk(bus_oe === 1'b1 && adc_en === 1'b1, "wake");
  endtask : t_pwr
  task automatic t_refuse;
    put(4'h6, 3'h1);
    put(4'h3, 3'h0, 15);
    chk(cfg.power_mode === 4'h6 && cfg.aux_disable === 3'h1, "short");
    put(4'h3, 3'h6, 16, 4'h1);
    chk(cfg.power_mode === 4'h6 && cfg.aux_disable === 3'h1, "sel");
    put(4'hF, 3'h4);
    chk(cfg.power_mode === 4'h6 && aux_en === 3'h3, "undef");
  endtask : t_refuse
  task automatic t_hold;
    put(4'h6, 3'h0);
    ce = 1'b0;
    put(4'hD, 3'h7);
    chk(cfg.power_mode === 4'h6 && aux_en === 3'h7, "frozen");
    ce = 1'b1;
    repeat (6) @(negedge clk);
    chk(cfg.power_mode === 4'hD && aux_en === 3'h0, "thawed");
    rstn = 1'b0;
    repeat (2) @(negedge clk);
    rstn = 1'b1;
    @(negedge clk);
    chk(cfg.power_mode === 4'h4 && tx_state === 1'b0 &&
        aux_en === 3'h7, "re-reset");
  endtask : t_hold
  initial begin
    rstn = 1'b0;
    ce = 1'b1;
    adc_sample = 10'h000;
    bus_in = 10'h000;
    repeat (4) @(negedge clk);
    rstn = 1'b1;
    @(negedge clk);
    chk(cfg.power_mode === 4'h4 && adc_en === 1'b1 && dac_en === 1'b0 &&
        tx_state === 1'b0 && aux_en === 3'h7, "reset");
    t_pin;
    t_cmd;
    t_pwr;
    t_refuse;
    t_hold;
    summarize;
  end
endmodule : afepm_top_bench
`default_nettype wire
